// ### src/scpi_consts.svh
// Character codes, node numbers and error codes of the message interpreter.
// Assumes 8-bit ASCII bytes from the bus interface.
`ifndef SCPI_CONSTS_SVH
`define SCPI_CONSTS_SVH

`define CH_LF        8'h0A
`define CH_SPACE     8'h20
`define CH_STAR      8'h2A
`define CH_COLON     8'h3A
`define CH_SEMI      8'h3B
`define CH_QMARK     8'h3F
`define CH_ZERO      8'h30
`define CH_ONE       8'h31
`define WORD_CHARS   12
`define NODE_CNT     13
`define NODE_ROOT    4'hF
`define NODE_STATUS  4'h0
`define NODE_OPER    4'h1
`define NODE_SYSTEM  4'h7
`define NODE_OPTROOT 4'hA
`define CMN_CLS      4'h0
`define CMN_OPC      4'h6
`define ERR_HEADER   8'h31
`define ERR_LONG     8'h32

`endif

// ### src/scpi_pkg.sv
// Types shared by the message interpreter and its output queue.
// Assumes the constants header is compiled alongside.
package scpi_pkg;
    typedef logic [3:0] node_t;
    typedef enum logic [2:0] {
        ST_WORD, ST_PARAM, ST_DISCARD, ST_PUSH_SEP, ST_PUSH_VAL, ST_PUSH_LF
    } parse_state_t;
    typedef struct packed {
        logic [95:0] name;
        node_t       parent;
        logic        is_path;
        logic        err_read;
    } node_info_t;
    typedef struct packed {
        logic       common;
        logic [3:0] code;
        logic       query;
    } exec_t;
    typedef struct packed {
        logic       eoi;
        logic [7:0] chr;
    } out_t;
endpackage

// ### src/scpi_message_parser.sv
// Program message interpreter with path pointer, error queue and output queue.
// Assumes one byte per handshake from the bus interface, synchronous to sys_clk.
// Operation
// (R1) A common command is an asterisk and three letters, unlike colon paths.
// (R2) Semicolons split one message into commands, each processed in turn.
// (R3) Each colon inside a path moves the pointer one level down.
// (R4) A colon right after a semicolon returns the pointer to root.
// (R5) A command after a semicolon without colon decodes at the current level.
// (R6) After a root reset, a word that is not a root word is an error.
// (R7) Each message starts at root; optional root children count as root words.
// (R8) A leading colon at message start is allowed and changes nothing.
// (R9) The path pointer never moves up a level.
// (R10) A common command runs at any level and leaves the pointer alone.
// (R11) The controller ends each message with line feed, end flag, or both.
// (R12) Commands of one message execute strictly in arrival order.
// (R13) An invalid command raises an error and is not executed.
// (R14) Commands before an invalid one run; those after it are discarded.
// (R15) Query responses wait in the output queue until addressed to talk.
// (R16) Errors are stored as they arise in a first-in first-out queue.
// (R17) Either error-read query moves the oldest error into the output queue.
// (R18) Several responses go out in order, separated by semicolons.
// (R19) Every response ends with a line feed together with the end flag.
// (R20) The controller sends queries first, then addresses the device to talk.
// (R21) The controller reads the whole response before the next message.
// (R22) Command words match regardless of letter case.
// (R23) Only full long form or exact short form is accepted.
// (R24) Short form cuts before a vowel fourth letter, otherwise after it.
// (R25) Bytes arrive singly with an end flag; each terminator resets to root.
`include "scpi_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module resp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("resp_fifo depth must be a power of two of at least two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem[rd_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_q + AW'(push);
            rd_q  <= rd_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module scpi_message_parser
    import scpi_pkg::*;
#(
    parameter int OUTQ_DEPTH = 16,
    parameter int ERRQ_DEPTH = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       rx_valid,
    output logic            rx_ready,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_end,
    input  wire logic       talk_addressed,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output logic      [7:0] tx_byte,
    output logic            tx_eoi,
    input  wire logic [7:0] query_value,
    output logic            exec_valid,
    output exec_t           exec_cmd
);
    localparam int EW = $clog2(ERRQ_DEPTH);
    if (ERRQ_DEPTH < 2 || (1 << EW) != ERRQ_DEPTH) begin : g_chk
        $error("error queue depth must be a power of two of at least two");
    end

    function automatic node_info_t node_info(input node_t id);
        node_info_t n;
        n = '0;
        case (id)
            4'h0: n = '{{"STATUS", 48'h0}, `NODE_ROOT, 1'b1, 1'b0};
            4'h1: n = '{{"OPERATION", 24'h0}, `NODE_STATUS, 1'b1, 1'b0};
            4'h2: n = '{{"PTRANSITION", 8'h0}, `NODE_OPER, 1'b0, 1'b0};
            4'h3: n = '{{"NTRANSITION", 8'h0}, `NODE_OPER, 1'b0, 1'b0};
            4'h4: n = '{{"ENABLE", 48'h0}, `NODE_OPER, 1'b0, 1'b0};
            4'h5: n = '{{"PRESET", 48'h0}, `NODE_STATUS, 1'b0, 1'b0};
            4'h6: n = '{{"QUEUE", 56'h0}, `NODE_STATUS, 1'b0, 1'b1};
            4'h7: n = '{{"SYSTEM", 48'h0}, `NODE_ROOT, 1'b1, 1'b0};
            4'h8: n = '{{"ERROR", 56'h0}, `NODE_SYSTEM, 1'b0, 1'b1};
            4'h9: n = '{{"PRESET", 48'h0}, `NODE_SYSTEM, 1'b0, 1'b0};
            4'hA: n = '{{"ROUTE", 56'h0}, `NODE_ROOT, 1'b1, 1'b0};
            4'hB: n = '{{"OPEN", 64'h0}, `NODE_OPTROOT, 1'b0, 1'b0};
            4'hC: n = '{{"SCAN", 64'h0}, `NODE_OPTROOT, 1'b0, 1'b0};
            default: n = '0;
        endcase
        return n;
    endfunction

    // The received word is compared against the long form and the derived short form.
    function automatic logic word_eq(input logic [95:0] w, input logic [3:0] wl,
                                     input logic [95:0] nm);
        logic [3:0] nl;
        logic [3:0] sl;
        logic [7:0] c4;
        logic       ok;
        nl = '0;
        for (int i = 0; i < `WORD_CHARS; i++) begin
            if (nm[95-8*i -: 8] != 8'h00) begin
                nl = nl + 4'h1;
            end
        end
        c4 = nm[71:64];
        sl = (nl <= 4'h4) ? nl : ((c4 == "A" || c4 == "E" || c4 == "I" ||
              c4 == "O" || c4 == "U") ? 4'h3 : 4'h4); // R24
        ok = (wl == nl || wl == sl) && wl != 4'h0; // R23
        for (int i = 0; i < `WORD_CHARS; i++) begin
            if (4'(i) < wl && w[95-8*i -: 8] != nm[95-8*i -: 8]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [4:0] find_node(input logic [95:0] w, input logic [3:0] wl,
                                             input node_t cur, input logic want_path);
        logic [4:0] r;
        node_info_t n;
        r = '0;
        for (int i = 0; i < `NODE_CNT; i++) begin
            n = node_info(4'(i));
            if (word_eq(w, wl, n.name) && n.is_path == want_path &&
                (n.parent == cur || (cur == `NODE_ROOT && n.parent == `NODE_OPTROOT))) begin
                r = {1'b1, 4'(i)}; // R5 R6 R7
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] common_code(input logic [23:0] w);
        case (w)
            "CLS": return {1'b1, `CMN_CLS};
            "ESE": return 5'h11;
            "ESR": return 5'h12;
            "IDN": return 5'h13;
            "OPT": return 5'h14;
            "RCL": return 5'h15;
            "OPC": return {1'b1, `CMN_OPC};
            "RST": return 5'h17;
            "SAV": return 5'h18;
            "SRE": return 5'h19;
            "STB": return 5'h1A;
            "TRG": return 5'h1B;
            "TST": return 5'h1C;
            "WAI": return 5'h1D;
            default: return 5'h00;
        endcase
    endfunction

    parse_state_t st_q, st_d, after_q, after_d;
    node_t        cur_q, cur_d;
    logic [95:0]  word_q, word_d;
    logic [3:0]   len_q, len_d;
    logic         com_q, com_d, qry_q, qry_d, cs_q, cs_d, resp_q, resp_d;
    logic [7:0]   val_q, val_d;
    logic         exv_d;
    exec_t        exc_d;
    logic         err_push, err_pop, err_clr;
    logic [7:0]   err_code;
    logic [7:0]   errq_mem [ERRQ_DEPTH];
    logic [EW-1:0] ewr_q, erd_q;
    logic [EW:0]  ecnt_q;

    wire       rx_fire  = rx_valid && rx_ready;
    wire       is_colon = rx_byte == `CH_COLON;
    wire       is_semi  = rx_byte == `CH_SEMI;
    wire       is_space = rx_byte == `CH_SPACE;
    wire       is_qm    = rx_byte == `CH_QMARK;
    wire       is_star  = rx_byte == `CH_STAR;
    wire       is_lf    = rx_byte == `CH_LF;
    wire       is_term  = is_lf || rx_end; // R11 R25
    wire       is_ch    = !(is_colon || is_semi || is_space || is_qm || is_star || is_lf);
    wire [7:0] up       = (rx_byte >= "a" && rx_byte <= "z") ? rx_byte - 8'h20 : rx_byte;
    wire       too_long = is_ch && len_q == 4'(`WORD_CHARS);
    wire       app      = is_ch && !too_long;
    wire [95:0] w_cur   = app ? (word_q | ({up, 88'h0} >> (8 * len_q))) : word_q; // R22
    wire [3:0] l_cur    = len_q + 4'(app);
    wire       com_cur  = com_q || is_star;
    wire       qry_cur  = qry_q || is_qm;
    wire [4:0] path_hit = find_node(w_cur, l_cur, cur_q, 1'b1);
    wire [4:0] leaf_hit = find_node(w_cur, l_cur, cur_q, 1'b0);
    wire [4:0] cmn_hit  = common_code(w_cur[95:72]);
    wire       cmn_ok   = cmn_hit[4] && l_cur == 4'h3; // R1
    wire       cmd_ok   = com_cur ? cmn_ok : leaf_hit[4];
    node_info_t leaf_nd;
    node_info_t cur_nd;
    assign leaf_nd = node_info(leaf_hit[3:0]);
    assign cur_nd  = node_info(cur_q);
    wire       leaf_er  = !com_cur && leaf_nd.err_read;
    wire       cmd_end  = is_semi || is_term || is_space;
    wire       have_cmd = l_cur != 4'h0 || com_cur;
    wire       in_word  = st_q == ST_WORD && rx_fire;
    wire       in_skip  = (st_q == ST_PARAM || st_q == ST_DISCARD) && rx_fire;
    wire [7:0] err_head = errq_mem[erd_q];
    wire       errq_any = ecnt_q != '0;

    logic  q_valid, q_ready;
    logic  tx_valid_raw;
    out_t  q_in, q_out;
    assign rx_ready = st_q == ST_WORD || st_q == ST_PARAM || st_q == ST_DISCARD;
    assign q_valid  = st_q == ST_PUSH_SEP || st_q == ST_PUSH_VAL || st_q == ST_PUSH_LF;
    assign q_in.eoi = st_q == ST_PUSH_LF; // R19
    assign q_in.chr = (st_q == ST_PUSH_SEP) ? `CH_SEMI :
                      (st_q == ST_PUSH_LF) ? `CH_LF : val_q; // R18
    assign tx_byte  = q_out.chr;
    assign tx_eoi   = q_out.eoi;

    resp_fifo #(.WIDTH($bits(out_t)), .DEPTH(OUTQ_DEPTH)) u_outq (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (q_valid),
        .in_ready  (q_ready),
        .in_data   (q_in),
        .out_valid (tx_valid_raw),
        .out_ready (tx_ready && talk_addressed),
        .out_data  (q_out)
    );
    assign tx_valid = tx_valid_raw && talk_addressed; // R15

    always_comb begin
        st_d = st_q;  after_d = after_q;  cur_d = cur_q;  word_d = word_q;
        len_d = len_q;  com_d = com_q;  qry_d = qry_q;  cs_d = cs_q;
        resp_d = resp_q;  val_d = val_q;  exv_d = 1'b0;  exc_d = '0;
        err_push = 1'b0;  err_pop = 1'b0;  err_clr = 1'b0;  err_code = `ERR_HEADER;
        if (in_word) begin
            word_d = w_cur;  len_d = l_cur;  com_d = com_cur;  qry_d = qry_cur;
            cs_d = cs_q && is_space;
            if (too_long) begin
                err_push = 1'b1; // R13
                err_code = `ERR_LONG;
                st_d = ST_DISCARD; // R14
            end else if (is_colon && l_cur == 4'h0) begin
                if (cs_q && !com_cur) begin
                    cur_d = `NODE_ROOT; // R4 R8
                end else begin
                    err_push = 1'b1;
                    st_d = ST_DISCARD;
                end
            end else if (is_colon) begin
                word_d = '0;  len_d = '0;
                if (!com_cur && !qry_cur && path_hit[4]) begin
                    cur_d = path_hit[3:0]; // R3 R9
                end else begin
                    err_push = 1'b1;
                    st_d = ST_DISCARD;
                end
            end else if (cmd_end && have_cmd) begin
                word_d = '0;  len_d = '0;  com_d = 1'b0;  qry_d = 1'b0;
                if (cmd_ok) begin
                    exv_d = 1'b1; // R12
                    exc_d = '{com_cur, com_cur ? cmn_hit[3:0] : leaf_hit[3:0], qry_cur};
                    err_clr = com_cur && cmn_hit[3:0] == `CMN_CLS && !qry_cur;
                    st_d = is_space ? ST_PARAM : ST_WORD; // R10
                    if (qry_cur) begin
                        err_pop = leaf_er && errq_any; // R17
                        val_d = leaf_er ? (errq_any ? err_head : `CH_ZERO) :
                                (com_cur && cmn_hit[3:0] == `CMN_OPC) ? `CH_ONE :
                                query_value;
                        after_d = is_term ? ST_PUSH_LF : st_d;
                        st_d = resp_q ? ST_PUSH_SEP : ST_PUSH_VAL; // R15 R18
                    end
                end else begin
                    err_push = 1'b1; // R13
                    st_d = ST_DISCARD; // R14
                end
            end
            if (is_semi && !err_push) begin
                cs_d = 1'b1; // R2
            end
        end
        if (in_skip && is_semi && st_q == ST_PARAM) begin
            st_d = ST_WORD;
            cs_d = 1'b1; // R2
        end
        if ((in_word || in_skip) && is_term) begin
            cur_d = `NODE_ROOT; // R7 R25
            cs_d = 1'b1;
            word_d = '0;  len_d = '0;  com_d = 1'b0;  qry_d = 1'b0;
            if (st_d != ST_PUSH_SEP && st_d != ST_PUSH_VAL) begin
                st_d = resp_q ? ST_PUSH_LF : ST_WORD;
            end
        end
        if (q_ready) begin
            case (st_q)
                ST_PUSH_SEP: st_d = ST_PUSH_VAL;
                ST_PUSH_VAL: begin
                    st_d = after_q;
                    resp_d = 1'b1;
                end
                ST_PUSH_LF: begin
                    st_d = ST_WORD;
                    resp_d = 1'b0;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= ST_WORD;  after_q <= ST_WORD;  cur_q <= `NODE_ROOT;
            word_q <= '0;  len_q <= '0;  com_q <= 1'b0;  qry_q <= 1'b0;
            cs_q <= 1'b1;  resp_q <= 1'b0;  val_q <= 8'h00;
            exec_valid <= 1'b0;  exec_cmd <= '0;
        end else begin
            st_q <= st_d;  after_q <= after_d;  cur_q <= cur_d;
            word_q <= word_d;  len_q <= len_d;  com_q <= com_d;  qry_q <= qry_d;
            cs_q <= cs_d;  resp_q <= resp_d;  val_q <= val_d;
            exec_valid <= exv_d;  exec_cmd <= exc_d;
        end
    end

    // A full error queue drops the newest error so the oldest stays readable.
    wire err_wr = err_push && ecnt_q != (EW+1)'(ERRQ_DEPTH);
    always_ff @(posedge sys_clk) begin
        if (err_wr) begin
            errq_mem[ewr_q] <= err_code; // R16
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn || err_clr) begin
            ewr_q <= '0;  erd_q <= '0;  ecnt_q <= '0;
        end else begin
            ewr_q  <= ewr_q + EW'(err_wr);
            erd_q  <= erd_q + EW'(err_pop);
            ecnt_q <= ecnt_q + (EW+1)'(err_wr) - (EW+1)'(err_pop);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_root_reset;
        in_word && is_colon && len_q == 4'h0 && cs_q && !com_q |=> cur_q == `NODE_ROOT;
    endproperty
    a_root_reset: assert property (p_root_reset) else $error("colon after separator kept path"); // R4
    property p_only_down;
        $changed(cur_q) |-> cur_q == `NODE_ROOT || cur_nd.parent == $past(cur_q) ||
            ($past(cur_q) == `NODE_ROOT && cur_nd.parent == `NODE_OPTROOT);
    endproperty
    a_only_down: assert property (p_only_down) else $error("path pointer moved up"); // R9
    property p_common_keeps;
        exec_valid && exec_cmd.common && !$past(is_term) |-> $stable(cur_q);
    endproperty
    a_common_keeps: assert property (p_common_keeps) else $error("common command moved path"); // R10
    property p_err_discards;
        err_push && !is_term |=> st_q == ST_DISCARD && !exec_valid ##1 !exec_valid;
    endproperty
    a_err_discards: assert property (p_err_discards) else $error("invalid command executed"); // R14
    property p_term_root;
        (in_word || in_skip) && is_term |=> cur_q == `NODE_ROOT && cs_q;
    endproperty
    a_term_root: assert property (p_term_root) else $error("terminator left path set"); // R25
    property p_talk_only;
        tx_valid_raw && !talk_addressed |=> tx_valid_raw && $stable(q_out);
    endproperty
    a_talk_only: assert property (p_talk_only) else $error("response lost while not talker"); // R15
    property p_eoi_lf;
        tx_valid && tx_eoi |-> tx_byte == `CH_LF;
    endproperty
    a_eoi_lf: assert property (p_eoi_lf) else $error("end flag without line feed"); // R19
    property p_err_pop;
        err_pop |=> ecnt_q == $past(ecnt_q) - 1'b1;
    endproperty
    a_err_pop: assert property (p_err_pop) else $error("error read did not pop queue"); // R17
    property p_sep_first;
        st_q == ST_PUSH_SEP && q_ready |=> st_q == ST_PUSH_VAL;
    endproperty
    a_sep_first: assert property (p_sep_first) else $error("separator not followed by value"); // R18
endmodule

`default_nettype wire

// ### sim/bus_host.sv
// Bus controller model: sends program messages byte by byte and reads responses.
// Assumes the interpreter's byte handshake and talk gating, all on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module bus_host
    import scpi_pkg::*;
(
    input  wire logic       sys_clk,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic      [7:0] rx_byte,
    output logic            rx_end,
    output logic            talk_addressed,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_eoi
);
    out_t rsp[$];

    initial begin
        rx_valid       = 1'h0;
        rx_byte        = 8'h00;
        rx_end         = 1'h0;
        talk_addressed = 1'h0;
        tx_ready       = 1'h0;
    end

    // Each message ends with a line feed, the end flag on its last byte, or both.
    task automatic send(input string s, input bit eoi);
        for (int i = 0; i < s.len(); i++) begin
            rx_valid = 1'h1;
            rx_byte  = s[i];
            rx_end   = eoi && (i == s.len() - 1);
            while (rx_ready !== 1'h1) begin
                @(posedge sys_clk);
                #1;
            end
            @(posedge sys_clk);
            #1;
        end
        // A released lane shows the inverse of its last byte, so stale data never matches.
        rx_valid = 1'h0;
        rx_end   = 1'h0;
        rx_byte  = ~rx_byte;
    endtask

    // Talk is addressed only after the queries went out; the whole response is taken.
    task automatic read_resp(input int slow);
        rsp.delete();
        talk_addressed = 1'h1;
        for (int n = 0; n < 80; n++) begin
            @(posedge sys_clk);
            #1;
            if (rsp.size() > 0 && rsp[$].eoi === 1'h1) break;
            tx_ready = (n % (slow + 1)) == 0;
            if (tx_valid === 1'h1 && tx_ready) rsp.push_back('{eoi: tx_eoi, chr: tx_byte});
        end
        tx_ready       = 1'h0;
        talk_addressed = 1'h0;
    endtask
endmodule

`default_nettype wire

// ### sim/scpi_message_parser_tb.sv
// Self-checking bench for the program message interpreter.
// Assumes bus_host plays the controller; the design carries its own assertions.
`include "scpi_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module scpi_message_parser_tb
    import scpi_pkg::*;
();
    logic       sys_clk;
    logic       rstn;
    logic       rx_valid;
    logic       rx_ready;
    logic [7:0] rx_byte;
    logic       rx_end;
    logic       talk_addressed;
    logic       tx_valid;
    logic       tx_ready;
    logic [7:0] tx_byte;
    logic       tx_eoi;
    logic [7:0] query_value;
    logic       exec_valid;
    exec_t      exec_cmd;
    exec_t      exq[$];
    int         err_count = 0;
    int         n_checks = 0;
    int         cyc_count = 0;

    scpi_message_parser #(.OUTQ_DEPTH(16), .ERRQ_DEPTH(8)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_byte(rx_byte), .rx_end(rx_end), .talk_addressed(talk_addressed),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_eoi(tx_eoi),
        .query_value(query_value), .exec_valid(exec_valid), .exec_cmd(exec_cmd));

    bus_host host (
        .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
        .rx_end(rx_end), .talk_addressed(talk_addressed), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_eoi(tx_eoi));

    always #50 sys_clk = ~sys_clk;

    // Sampled on the falling edge so the registered pulse has settled.
    always @(negedge sys_clk) begin
        if (exec_valid === 1'h1) exq.push_back(exec_cmd);
    end

    always @(posedge sys_clk) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            err_count++;
            $display("ERROR at %0t: timeout, cycles %h expected below %h", $time, cyc_count, 20000);
            close_out();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic msg(input string s, input bit eoi);
        exq.delete();
        host.send(s, eoi);
        cyc(4);
        while (rx_ready !== 1'h1) cyc(1);
    endtask

    task automatic ex(input logic c, input logic [3:0] code, input logic q);
        exec_t got;
        got = 6'h3F;
        if (exq.size() > 0) got = exq.pop_front();
        chk({2'h0, got}, {2'h0, c, code, q});
    endtask

    task automatic noex();
        chk(8'(exq.size()), 8'h00);
    endtask

    task automatic rsp(input string s, input int slow);
        host.read_resp(slow);
        chk(8'(host.rsp.size()), 8'(s.len()));
        for (int i = 0; i < s.len() && i < host.rsp.size(); i++) begin
            chk(host.rsp[i].chr, s[i]);
            chk({7'h00, host.rsp[i].eoi}, {7'h00, i == s.len() - 1});
        end
    endtask

    task automatic t_opc();
        msg("*opc?\n", 1'h1);
        ex(1'h1, `CMN_OPC, 1'h1);
        chk({7'h00, tx_valid}, 8'h00);
        rsp("1\n", 0);
        $display("Test opc done");
    endtask

    task automatic t_multi();
        msg("*OPC?;*OPC?;*opc?", 1'h1);
        ex(1'h1, `CMN_OPC, 1'h1);
        ex(1'h1, `CMN_OPC, 1'h1);
        ex(1'h1, `CMN_OPC, 1'h1);
        rsp("1;1;1\n", 2);
        $display("Test multi done");
    endtask

    task automatic t_path();
        msg("stat:oper:enab 5;ptr 3;*ESE 1;ntr 2\n", 1'h0);
        ex(1'h0, 4'h4, 1'h0);
        ex(1'h0, 4'h2, 1'h0);
        ex(1'h1, 4'h1, 1'h0);
        ex(1'h0, 4'h3, 1'h0);
        msg("syst:err?\n", 1'h0);
        rsp("0\n", 0);
        $display("Test path done");
    endtask

    task automatic t_root();
        msg("stat:oper:enab 1;:ptr 2\n", 1'h0);
        ex(1'h0, 4'h4, 1'h0);
        noex();
        msg("stat:que?\n", 1'h0);
        rsp("1\n", 1);
        $display("Test root done");
    endtask

    task automatic t_discard();
        msg(":rout:open all;harve;scan?\n", 1'h0);
        ex(1'h0, 4'hB, 1'h0);
        noex();
        msg("abcdefghijklm\n", 1'h0);
        msg("SYSTEM:ERROR?;:STATus:QUEue?;:syst:err?\n", 1'h0);
        rsp("1;2;0\n", 0);
        $display("Test discard done");
    endtask

    task automatic t_forms();
        msg("stat:pres\n", 1'h0);
        ex(1'h0, 4'h5, 1'h0);
        msg(":STAT:PRES\n", 1'h0);
        ex(1'h0, 4'h5, 1'h0);
        msg("open\n", 1'h0);
        ex(1'h0, 4'hB, 1'h0);
        msg("statu:pres\n", 1'h0);
        noex();
        msg("Status:PRESET;:syst:prese\n", 1'h0);
        ex(1'h0, 4'h5, 1'h0);
        noex();
        msg(":scan?\n", 1'h0);
        ex(1'h0, 4'hC, 1'h1);
        rsp("7\n", 0);
        msg("*cls", 1'h1);
        ex(1'h1, `CMN_CLS, 1'h0);
        msg("syst:err?\n", 1'h0);
        rsp("0\n", 0);
        $display("Test forms done");
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        sys_clk     = 1'h0;
        rstn        = 1'h0;
        query_value = 8'h37;
        repeat (16) @(posedge sys_clk);
        #1;
        rstn = 1'h1;
        t_opc();
        t_multi();
        t_path();
        t_root();
        t_discard();
        t_forms();
        close_out();
    end
endmodule

`default_nettype wire
